// ==== src/bsc_map.svh ====
// Purpose: Offsets, fields, reset values and timing of the converter control block
// Assumes: CLOCK at 20 MHz, Wishbone words at aligned byte addresses
// Notes: Soft-start and delay durations are in microseconds and their cycle counts derive from them; init and switching divider are in cycles
`ifndef BSC_MAP_SVH
`define BSC_MAP_SVH

`define BSC_CLK_MHZ 20
`define BSC_SS_T0_US 500
`define BSC_SS_T1_US 1000
`define BSC_SS_T2_US 2000
`define BSC_SS_T3_US 4000
`define BSC_DLY_US 10
`define BSC_INIT_CYC 64
`define BSC_SW_DIV 8

`define BSC_ADR_CTL1 8'h00
`define BSC_ADR_CTL2 8'h04
`define BSC_ADR_CTL3 8'h08
`define BSC_ADR_SET 8'h0C
`define BSC_ADR_STAT 8'h10

`define BSC_C1_FORCED_PWM_MODE 0
`define BSC_C1_RNG 1
`define BSC_C1_RAMP 3
`define BSC_C1_SPREAD 5
`define BSC_C2_SS 0
`define BSC_C3_SINGLE 0

`define BSC_C1_RST 8'h04
`define BSC_C2_RST 8'h01
`define BSC_C3_RST 8'h00

`endif

// ==== src/bsc_pkg.sv ====
// Purpose: Types shared by the converter control block
// Assumes: Nothing beyond SystemVerilog 2012
// Notes: Constants live in bsc_map.svh
`default_nettype none
package bsc_pkg;
	typedef enum {ST_INIT, ST_OFF, ST_DELAY, ST_RAMP, ST_RUN} bsc_state_t;
	typedef enum logic [1:0] {CM_OFF, CM_CCM, CM_DCM, CM_PFM} bsc_cmode_t;
	typedef struct packed {
		logic [1:0] voltage_select_pin;
		logic [1:0] frequency_select_pin;
		logic sync_out;
	} bsc_cfg_t;
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [7:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} bsc_wb_req_t;
endpackage
`default_nettype wire

// ==== src/bsc_sync.sv ====
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: Inputs are asynchronous levels
// Notes: First stage feeds only the second stage
`default_nettype none
module bsc_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			logic meta_r;
			logic sync_r;
			always_ff @(posedge clk) begin
				if (rst) begin
					meta_r <= 1'b0;
					sync_r <= 1'b0;
				end else if (ce) begin
					meta_r <= d[i];
					sync_r <= meta_r;
				end
			end
			assign q[i] = sync_r;
		end
	endgenerate
endmodule
`default_nettype wire

// ==== src/bsc_ctrl.sv ====
// Purpose: Mode selection, enable handshake and start-up sequence
// Assumes: Classic Wishbone slave, byte lane 0 carries register data
// Notes: Supply loss restarts initialisation and reloads defaults
`include "bsc_map.svh"
`default_nettype none
module bsc_ctrl #(
	parameter int SS_CYC0 = `BSC_SS_T0_US * `BSC_CLK_MHZ,
	parameter int SS_CYC1 = `BSC_SS_T1_US * `BSC_CLK_MHZ,
	parameter int SS_CYC2 = `BSC_SS_T2_US * `BSC_CLK_MHZ,
	parameter int SS_CYC3 = `BSC_SS_T3_US * `BSC_CLK_MHZ,
	parameter int DLY_CYC = `BSC_DLY_US * `BSC_CLK_MHZ,
	parameter int INIT_CYC = `BSC_INIT_CYC,
	parameter int SW_DIV = `BSC_SW_DIV,
	parameter bit HAS_SERIAL = 1'b1,
	parameter logic [7:0] SET_DEF0 = 8'h46,
	parameter logic [7:0] SET_DEF1 = 8'h50,
	parameter logic [7:0] SET_DEF2 = 8'h50,
	parameter logic [7:0] SET_DEF3 = 8'h5F
) (
	input wire logic CLOCK,
	input wire logic RST,
	input wire logic CE,
	input wire bsc_pkg::bsc_wb_req_t WB_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	input wire logic MODE_PIN,
	input wire logic EN_IN,
	output logic EN_OUT,
	output logic EN_OE,
	input wire logic SUPPLY_OK,
	input wire logic FAULT_TSD,
	input wire logic FAULT_OVP,
	input wire logic [1:0] LOAD_LVL,
	input wire logic PULSE_REQ,
	input wire logic [1:0] VOLTAGE_SELECT_PIN_PIN,
	input wire logic [1:0] FREQUENCY_SELECT_PIN_PIN,
	input wire logic SYNC_OUT_PIN,
	output bsc_pkg::bsc_cfg_t CFG_O,
	output logic REF_EN,
	output logic SERIAL_OPEN,
	output logic SWITCH_EN,
	output bsc_pkg::bsc_cmode_t CONV_MODE,
	output logic PULSE_OUT,
	output logic RAMP_ACTIVE,
	output logic [7:0] TARGET_SET,
	output logic [1:0] TARGET_RANGE,
	output logic [1:0] RAMP_RATE
);
	import bsc_pkg::*;

	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (RST);

	// ==========================================
	// Pin synchronisation
	logic [12:0] sq;
	logic mode_s;
	logic en_s;
	logic supply_s;
	logic fault_s;
	logic [1:0] load_s;
	logic preq_s;
	logic [1:0] voltage_select_pin_s;
	logic [1:0] frequency_select_pin_s;
	logic syo_s;

	bsc_sync #(.W(13)) u_sync (
		.clk(CLOCK),
		.rst(RST),
		.ce(CE),
		.d({MODE_PIN, EN_IN, SUPPLY_OK, FAULT_TSD, FAULT_OVP, LOAD_LVL,
			PULSE_REQ, VOLTAGE_SELECT_PIN_PIN, FREQUENCY_SELECT_PIN_PIN, SYNC_OUT_PIN}),
		.q(sq)
	);

	assign {mode_s, en_s, supply_s} = sq[12:10];
	assign fault_s = sq[9] | sq[8];
	assign load_s = sq[7:6];
	assign preq_s = sq[5];
	assign voltage_select_pin_s = sq[4:3];
	assign frequency_select_pin_s = sq[2:1];
	assign syo_s = sq[0];

	// Supply loss behaves as a power-on reset of everything past the synchroniser except the Wishbone ack and read data, which only RST clears
	logic pwr_rst;
	assign pwr_rst = RST | !supply_s;

	// ==========================================
	// Registers
	logic [7:0] c1_r;
	logic [7:0] c2_r;
	logic [7:0] c3_r;
	logic [7:0] set_r;
	logic forced_pwm_mode_bit;
	logic spread_bit;
	logic single_bit;
	assign forced_pwm_mode_bit = c1_r[`BSC_C1_FORCED_PWM_MODE];
	assign spread_bit = c1_r[`BSC_C1_SPREAD];
	assign single_bit = c3_r[`BSC_C3_SINGLE];

	bsc_state_t st_r;
	bsc_state_t st_nxt;
	logic [31:0] cnt_r;
	logic [31:0] cnt_nxt;
	logic init_last;
	logic run_ok;
	logic open_r;
	assign init_last = (st_r == ST_INIT) && (cnt_r >= 32'(INIT_CYC - 1));
	assign run_ok = en_s && !fault_s;

	logic req;
	logic ack_r;
	logic wr_en;
	assign req = WB_I.cyc & WB_I.stb;
	// Write lands on the edge where the master sees ack
	assign wr_en = req & ack_r & WB_I.we & WB_I.sel[0] & open_r;

	function automatic logic [7:0] def_set(input logic [1:0] code);
		return code[1] ? (code[0] ? SET_DEF3 : SET_DEF2) : (code[0] ? SET_DEF1 : SET_DEF0);
	endfunction

	always_ff @(posedge CLOCK) begin
		if (pwr_rst) begin
			c1_r <= `BSC_C1_RST;
			c2_r <= `BSC_C2_RST;
			c3_r <= `BSC_C3_RST;
			set_r <= 8'h00;
		end else if (CE) begin
			if (init_last) begin
				set_r <= def_set(voltage_select_pin_s);
			end else if (wr_en) begin
				case (WB_I.adr)
					`BSC_ADR_CTL1: c1_r <= WB_I.dat[7:0];
					`BSC_ADR_CTL2: c2_r <= WB_I.dat[7:0];
					`BSC_ADR_CTL3: c3_r <= WB_I.dat[7:0];
					`BSC_ADR_SET: set_r <= WB_I.dat[7:0];
					default: ;
				endcase
			end
		end
	end

	// ==========================================
	// Start-up sequence
	logic [1:0] ss_dur_r;
	logic [31:0] ss_len;
	always_comb begin
		ss_len = 32'(SS_CYC1);
		unique case (ss_dur_r)
			2'h0: ss_len = 32'(SS_CYC0);
			2'h1: ss_len = 32'(SS_CYC1);
			2'h2: ss_len = 32'(SS_CYC2);
			2'h3: ss_len = 32'(SS_CYC3);
		endcase
	end

	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r + 32'h1;
		unique case (st_r)
			ST_INIT: begin
				if (init_last) begin
					st_nxt = ST_OFF;
					cnt_nxt = 32'h0;
				end
			end
			ST_OFF: begin
				cnt_nxt = 32'h0;
				if (run_ok) begin
					st_nxt = ST_DELAY;
				end
			end
			ST_DELAY: begin
				if (!run_ok) begin
					st_nxt = ST_OFF;
					cnt_nxt = 32'h0;
				end else if (cnt_r >= 32'(DLY_CYC - 1)) begin
					st_nxt = ST_RAMP;
					cnt_nxt = 32'h0;
				end
			end
			ST_RAMP: begin
				if (!run_ok) begin
					st_nxt = ST_OFF;
					cnt_nxt = 32'h0;
				end else if (cnt_r >= ss_len - 32'h1) begin
					st_nxt = ST_RUN;
					cnt_nxt = 32'h0;
				end
			end
			ST_RUN: begin
				cnt_nxt = 32'h0;
				if (!run_ok) begin
					st_nxt = ST_OFF;
				end
			end
		endcase
	end

	always_ff @(posedge CLOCK) begin
		if (pwr_rst) begin
			st_r <= ST_INIT;
			cnt_r <= 32'h0;
		end else if (CE) begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// Reference comes up first, then pins are read at the end of init
	always_ff @(posedge CLOCK) begin
		if (pwr_rst) begin
			REF_EN <= 1'b0;
			CFG_O <= '0;
		end else if (CE) begin
			REF_EN <= 1'b1;
			if (init_last) begin
				CFG_O <= '{voltage_select_pin: voltage_select_pin_s, frequency_select_pin: frequency_select_pin_s, sync_out: syo_s};
			end
		end
	end

	// ==========================================
	// Enable pin and access gate
	always_ff @(posedge CLOCK) begin
		if (pwr_rst) begin
			EN_OE <= 1'b1;
			EN_OUT <= 1'b0;
			open_r <= 1'b0;
			SERIAL_OPEN <= 1'b0;
		end else if (CE) begin
			EN_OUT <= 1'b0;
			// Stacked parts rely on this pulldown to stop together
			EN_OE <= (st_r == ST_INIT) | (fault_s & !single_bit);
			open_r <= (st_r != ST_INIT) & HAS_SERIAL;
			SERIAL_OPEN <= (st_r != ST_INIT) & HAS_SERIAL;
		end
	end

	// ==========================================
	// Targets captured at ramp start
	always_ff @(posedge CLOCK) begin
		if (pwr_rst) begin
			TARGET_SET <= 8'h00;
			TARGET_RANGE <= 2'h0;
			RAMP_RATE <= 2'h0;
			ss_dur_r <= 2'h1;
			RAMP_ACTIVE <= 1'b0;
		end else if (CE) begin
			RAMP_ACTIVE <= (st_nxt == ST_RAMP);
			// Taken at ramp start, then followed again only once the ramp is over
			if ((st_r == ST_DELAY && st_nxt == ST_RAMP) || st_r == ST_RUN) begin
				TARGET_SET <= set_r;
				TARGET_RANGE <= c1_r[`BSC_C1_RNG +: 2];
				RAMP_RATE <= c1_r[`BSC_C1_RAMP +: 2];
			end
			if (st_r == ST_DELAY && st_nxt == ST_RAMP) begin
				ss_dur_r <= c2_r[`BSC_C2_SS +: 2];
			end
		end
	end

	// ==========================================
	// Conduction mode and pulses
	logic [7:0] sw_cnt_r;
	logic sw_tick;
	logic forced;
	bsc_cmode_t load_mode;
	assign sw_tick = (sw_cnt_r == 8'h00);
	assign forced = mode_s | forced_pwm_mode_bit | spread_bit;
	always_comb begin
		if (load_s[1]) begin
			load_mode = CM_CCM;
		end else if (load_s[0]) begin
			load_mode = CM_DCM;
		end else begin
			load_mode = CM_PFM;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (pwr_rst) begin
			sw_cnt_r <= 8'h00;
		end else if (CE) begin
			sw_cnt_r <= sw_tick ? 8'(SW_DIV - 1) : sw_cnt_r - 8'h01;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (pwr_rst) begin
			CONV_MODE <= CM_OFF;
			SWITCH_EN <= 1'b0;
			PULSE_OUT <= 1'b0;
		end else if (CE) begin
			SWITCH_EN <= run_ok && (st_r == ST_RAMP || st_r == ST_RUN);
			if (st_r == ST_RAMP) begin
				CONV_MODE <= CM_DCM;
			end else if (st_r != ST_RUN || !run_ok) begin
				CONV_MODE <= CM_OFF;
			end else if (sw_tick) begin
				// Changing only on the switching tick keeps transitions clean
				CONV_MODE <= forced ? CM_CCM : load_mode;
			end
			PULSE_OUT <= sw_tick && SWITCH_EN && (CONV_MODE != CM_OFF) &&
				(CONV_MODE != CM_PFM || preq_s);
		end
	end

	// ==========================================
	// Wishbone answer
	logic [31:0] stat;
	assign stat = {19'h0, forced, syo_s, frequency_select_pin_s, voltage_select_pin_s, CONV_MODE, SWITCH_EN,
		RAMP_ACTIVE, fault_s, en_s, open_r};

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			ack_r <= 1'b0;
			WB_DAT_O <= 32'h0;
		end else if (CE) begin
			ack_r <= req & !ack_r;
			if (req & !ack_r) begin
				WB_DAT_O <= 32'h0;
				if (open_r) begin
					case (WB_I.adr)
						`BSC_ADR_CTL1: WB_DAT_O <= {24'h0, c1_r};
						`BSC_ADR_CTL2: WB_DAT_O <= {24'h0, c2_r};
						`BSC_ADR_CTL3: WB_DAT_O <= {24'h0, c3_r};
						`BSC_ADR_SET: WB_DAT_O <= {24'h0, set_r};
						`BSC_ADR_STAT: WB_DAT_O <= stat;
						default: WB_DAT_O <= 32'h0;
					endcase
				end
			end
		end
	end
	assign WB_ACK_O = ack_r;

	// ==========================================
	// Checks
	forced_pwm_mode_ccm_a: assert property (CE && !pwr_rst && st_r == ST_RUN && run_ok && sw_tick
		&& (mode_s || forced_pwm_mode_bit) |=> CONV_MODE == CM_CCM)
		else $error("forced PWM not continuous");
	spread_forced_pwm_mode_a: assert property (CE && !pwr_rst && st_r == ST_RUN && run_ok
		&& sw_tick && spread_bit |=> CONV_MODE == CM_CCM)
		else $error("spread spectrum without forced PWM");
	pulse_tick_a: assert property ($rose(PULSE_OUT) |-> $past(sw_tick))
		else $error("pulse off the switching tick");
	init_pull_a: assert property (CE && st_r == ST_INIT |=> EN_OE)
		else $error("enable released during init");
	fault_pull_a: assert property (CE && !pwr_rst && fault_s && !single_bit
		|=> EN_OE ##0 !SWITCH_EN)
		else $error("fault did not pull enable");
	single_rel_a: assert property ($past(CE) && !$past(pwr_rst) && $past(single_bit)
		&& $past(st_r) != ST_INIT |-> !EN_OE)
		else $error("standalone still pulls enable");
	off_quiet_a: assert property (CE && !en_s |=> !SWITCH_EN)
		else $error("switching while disabled");
	ramp_dcm_a: assert property (CE && !pwr_rst && st_r == ST_RAMP |=> CONV_MODE == CM_DCM)
		else $error("ramp not discontinuous");
	ramp_hold_a: assert property (st_r == ST_RAMP && $past(st_r) == ST_RAMP
		|-> $stable(TARGET_SET) && $stable(TARGET_RANGE))
		else $error("target moved during ramp");
endmodule
`default_nettype wire

// ==== tb/bsc_stack_peer.sv ====
// Purpose: Shared enable wire with a host driver and a stacked peer
// Assumes: Open-drain wire-AND, host pulls up through a resistor
// Notes: Peer pull stands for another converter in init or fault
`default_nettype none
module bsc_stack_peer (
	input wire logic host_en,
	input wire logic dev_oe,
	input wire logic dev_out,
	input wire logic peer_pull,
	output logic en_wire
);
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================
	// Wire level
	// Any pulldown wins over the host resistor
	assign en_wire = host_en & ~peer_pull & ~(dev_oe & ~dev_out);
endmodule
`default_nettype wire

// ==== tb/test_bsc_ctrl.sv ====
// Purpose: Register, enable, start-up and mode checks of the control block
// Assumes: Shortened soft-start, delay and init counts
// Notes: Host keeps the standalone bit cleared while stacked
`default_nettype none
module test_bsc_ctrl;
	timeunit 1ns;
	timeprecision 1ns;
	import bsc_pkg::*;
	localparam int SSC[4] = '{20, 40, 80, 160};
	logic CLOCK, RST, CE, mode_pin, host_en, peer_pull, en_in, en_out, en_oe;
	logic supply_ok, f_tsd, f_ovp, preq, syncp, ack, ref_en, ser_open, sw_en, pulse, ramp;
	logic [1:0] load, voltage_select_pin, frequency_select_pin, trange, rrate;
	logic [7:0] tset;
	logic [31:0] dat_o, rd;
	bsc_wb_req_t wb_i;
	bsc_cfg_t cfg;
	bsc_cmode_t cmode;
	int num_errors = 0;
	int samples_checked = 0;
	int cycles = 0;
	int n;
	logic [7:0] mt[7] = '{8'h03, 8'h06, 8'h09, 8'h11, 8'h41, 8'h21, 8'h83};

	bsc_ctrl #(.SS_CYC0(20), .SS_CYC1(40), .SS_CYC2(80), .SS_CYC3(160), .DLY_CYC(5),
		.INIT_CYC(8)) u_bsc_ctrl (.CLOCK(CLOCK), .RST(RST), .CE(CE), .WB_I(wb_i),
		.WB_DAT_O(dat_o), .WB_ACK_O(ack), .MODE_PIN(mode_pin), .EN_IN(en_in),
		.EN_OUT(en_out), .EN_OE(en_oe), .SUPPLY_OK(supply_ok), .FAULT_TSD(f_tsd),
		.FAULT_OVP(f_ovp), .LOAD_LVL(load), .PULSE_REQ(preq), .VOLTAGE_SELECT_PIN_PIN(voltage_select_pin),
		.FREQUENCY_SELECT_PIN_PIN(frequency_select_pin), .SYNC_OUT_PIN(syncp), .CFG_O(cfg), .REF_EN(ref_en),
		.SERIAL_OPEN(ser_open), .SWITCH_EN(sw_en), .CONV_MODE(cmode), .PULSE_OUT(pulse),
		.RAMP_ACTIVE(ramp), .TARGET_SET(tset), .TARGET_RANGE(trange), .RAMP_RATE(rrate));
	bsc_stack_peer u_bsc_stack_peer (.host_en(host_en), .dev_oe(en_oe), .dev_out(en_out),
		.peer_pull(peer_pull), .en_wire(en_in));

	// ==========================================
	// Clock and hang guard
	initial begin
		CLOCK = 0;
		forever #25 CLOCK = ~CLOCK;
	end
	always @(posedge CLOCK) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			num_errors++;
			close_out();
		end
	end

	// ==========================================
	// Tasks
	task close_out;
		if (num_errors == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task tick(input int k);
		repeat (k) @(posedge CLOCK);
	endtask
	// No limit of its own: the hang guard ends a wait that never finishes
	task wait_sig(input int k, input logic v);
		while ((k == 0 ? ramp : ser_open) !== v) begin
			@(posedge CLOCK);
		end
	endtask
	// Request stands until ack is sampled high, then cyc and stb drop for a cycle
	task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge CLOCK);
		wb_i <= '{cyc: 1'h1, stb: 1'h1, we: w, adr: a, sel: 4'hF, dat: {24'h0, d}};
		do begin
			@(posedge CLOCK);
		end while (ack !== 1'h1);
		rd = dat_o;
		wb_i <= '0;
	endtask
	// A nonzero hold drops CE early in the ramp; frozen cycles must not shorten it
	task run_ramp(input int code, input logic [7:0] exp_set, input int hold);
		wait_sig(0, 1'h1);
		chk(tset, exp_set);
		if (hold > 0) begin
			CE <= 1'h0;
			tick(hold);
			CE <= 1'h1;
		end
		n = 0;
		while (ramp === 1'h1) begin
			@(posedge CLOCK);
			n++;
			if (n == 2) chk(cmode, CM_DCM);
		end
		chk(32'(n), 32'(SSC[code]));
	endtask

	// ==========================================
	// Sequence
	initial begin
		RST = 1'h1;
		CE = 1'h1;
		wb_i = '0;
		mode_pin = 1'h0;
		host_en = 1'h0;
		peer_pull = 1'h0;
		supply_ok = 1'h1;
		f_tsd = 1'h0;
		f_ovp = 1'h0;
		load = 2'h0;
		preq = 1'h0;
		voltage_select_pin = 2'h3;
		frequency_select_pin = 2'h2;
		syncp = 1'h1;
		tick(12);
		chk(en_oe, 32'h1);
		RST <= 1'h0;
		wb(1'h0, 8'h04, 8'h00);
		chk(rd, 32'h0);
		wb(1'h1, 8'h08, 8'h01);
		wait_sig(1, 1'h1);
		tick(3);
		chk(en_oe, 32'h0);
		chk(ref_en, 32'h1);
		chk(cfg, 32'h1D);
		wb(1'h0, 8'h00, 8'h00);
		chk(rd, 32'h4);
		wb(1'h0, 8'h04, 8'h00);
		chk(rd, 32'h1);
		wb(1'h0, 8'h08, 8'h00);
		chk(rd, 32'h0);
		wb(1'h0, 8'h0C, 8'h00);
		chk(rd, 32'h5F);
		wb(1'h0, 8'h14, 8'h00);
		chk(rd, 32'h0);
		wb(1'h1, 8'h04, 8'h00);
		wb(1'h1, 8'h0C, 8'h40);
		tick(20);
		chk(sw_en, 32'h0);
		chk(cmode, CM_OFF);
		host_en <= 1'h1;
		wait_sig(0, 1'h1);
		wb(1'h1, 8'h0C, 8'h66);
		wb(1'h1, 8'h04, 8'h03);
		wb(1'h1, 8'h00, 8'h1A);
		chk(tset, 32'h40);
		chk(trange, 32'h2);
		wait_sig(0, 1'h0);
		tick(20);
		chk(tset, 32'h66);
		chk(trange, 32'h1);
		chk(rrate, 32'h3);
		host_en <= 1'h0;
		for (int c = 0; c < 4; c++) begin
			tick(8);
			chk(sw_en, 32'h0);
			wb(1'h1, 8'h04, 8'(c));
			wb(1'h1, 8'h0C, 8'h30 + 8'(c));
			host_en <= 1'h1;
			run_ramp(c, 8'h30 + 8'(c), (c == 1) ? 10 : 0);
			if (c < 3) host_en <= 1'h0;
		end
		tick(4);
		chk(sw_en, 32'h1);
		// Peer stays idle here, so the power save rows stand for a single part
		foreach (mt[i]) begin
			preq <= mt[i][7];
			mode_pin <= mt[i][6];
			load <= mt[i][3:2];
			wb(1'h1, 8'h00, {2'h0, mt[i][4], 2'h0, 2'h2, mt[i][5]});
			tick(24);
			chk(cmode, 32'(mt[i][1:0]));
			n = 0;
			repeat (80) begin
				@(posedge CLOCK);
				if (pulse === 1'h1) n++;
			end
			chk(32'(n), (mt[i][1:0] == 2'h3 && !mt[i][7]) ? 32'h0 : 32'hA);
		end
		peer_pull <= 1'h1;
		tick(8);
		chk(sw_en, 32'h0);
		peer_pull <= 1'h0;
		f_tsd <= 1'h1;
		tick(8);
		chk(en_oe, 32'h1);
		chk(en_out, 32'h0);
		chk(en_in, 32'h0);
		chk(sw_en, 32'h0);
		f_tsd <= 1'h0;
		tick(8);
		chk(en_oe, 32'h0);
		wb(1'h1, 8'h08, 8'h01);
		f_ovp <= 1'h1;
		tick(8);
		chk(en_oe, 32'h0);
		chk(sw_en, 32'h0);
		f_ovp <= 1'h0;
		wb(1'h1, 8'h08, 8'h00);
		chk(ser_open, 32'h1);
		// New pin codes while the supply is away must be the ones read at re-init
		supply_ok <= 1'h0;
		voltage_select_pin <= 2'h0;
		frequency_select_pin <= 2'h1;
		syncp <= 1'h0;
		tick(6);
		chk(en_oe, 32'h1);
		chk(ser_open, 32'h0);
		chk(sw_en, 32'h0);
		supply_ok <= 1'h1;
		wait_sig(1, 1'h1);
		chk(ser_open, 32'h1);
		chk(cfg, 32'h2);
		wb(1'h0, 8'h0C, 8'h00);
		chk(rd, 32'h46);
		wb(1'h0, 8'h08, 8'h00);
		chk(rd, 32'h0);
		close_out();
	end
endmodule
`default_nettype wire
